//--- hw/hqa_pkg.sv
// Shared constants for the HDLC host queue access block.
package hqa_pkg;

   // Byte addresses on the register bus.
   localparam logic [7:0] ADDR_WIN_LAST = 8'h1F;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_MASK = 8'h24;
   localparam logic [7:0] ADDR_CONFIG = 8'h28;
   localparam logic [7:0] ADDR_COMMAND = 8'h2C;
   localparam logic [7:0] ADDR_RX_COUNT = 8'h30;
   localparam logic [7:0] ADDR_QSTATE = 8'h34;

   // Values after reset.
   localparam logic [7:0] STATUS_RESET = 8'h10;
   localparam logic [7:0] MASK_RESET = 8'hFC;
   localparam logic [2:0] CONFIG_RESET = 3'h0;

   // Event bit positions in the status and mask registers.
   localparam int BIT_RX_END = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_RX_OVF = 5;
   localparam int BIT_TX_READY = 4;
   localparam int BIT_TX_REPEAT = 3;
   localparam int BIT_TX_UNDER = 2;
   localparam logic [7:0] STATUS_LIVE = 8'hFC;

   // Configuration fields.
   localparam int CFG_RX_BS_LO = 0;
   localparam int CFG_TX_BS = 2;

   // Command bits.
   localparam int CMD_RELEASE = 7;
   localparam int CMD_RX_RESET = 6;
   localparam int CMD_TX_FRAME = 3;
   localparam int CMD_TX_END = 1;
   localparam int CMD_TX_RESET = 0;

   // Queue geometry.
   localparam int QUEUE_DEPTH = 32;
   localparam logic [5:0] QUEUE_FULL = 6'd32;
   localparam logic [5:0] RX_BS_BASE = 6'd4;
   localparam logic [5:0] TX_BS_SMALL = 6'd16;
   localparam logic [5:0] TX_BS_LARGE = 6'd32;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- hw/hqa_queue_mem.sv
`timescale 1ns/1ps
// 32 by 8 queue storage with one write port and an unregistered read port.
module hqa_queue_mem
   import hqa_pkg::*;
(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [4:0] rd_addr,
   output logic [7:0] rd_data
);

   logic [7:0] mem [QUEUE_DEPTH];

   // Storage has no reset; pointers in the owner decide what is valid.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read is combinational so a bus read can capture it in one cycle.
   assign rd_data = mem[rd_addr];

endmodule // hqa_queue_mem

//--- hw/hqa_top.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - Reads in the low window return the byte at the read pointer, then advance.
// RL2 - The receive queue never holds more than 32 bytes.
// RL3 - Pool full is raised only once a complete block sits in the queue.
// RL4 - Receive block size is 4, 8, 16 or 32 bytes by configuration.
// RL5 - After message end the frame byte count is readable.
// RL6 - Writes in the low window store at the write pointer, then advance.
// RL7 - Host writes at most one transmit block after each pool ready.
// RL8 - Status resets to 0x10, events in bits 7..2, bits 1..0 zero.
// RL9 - Message end follows a short frame or the last part of a long one.
// RL10 - A frame meeting an occupied queue is dropped with overflow raised.
// RL11 - Pool ready is raised whenever a transmit block may be written; the code sets it only at reset and when a send drains the queue.
// RL12 - Empty queue mid-frame aborts with seven ones and raises underrun.
module hqa_top
   import hqa_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic RX_START,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_END,
   input wire logic TX_READY,
   input wire logic TX_COLLISION,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_END,
   output logic TX_ABORT,
   output logic IRQ
);

   // Receive block size in bytes from its two-bit selector.
   function automatic logic [5:0] rx_block_bytes(input logic [1:0] sel);
      rx_block_bytes = RX_BS_BASE << sel;
   endfunction

   // Address falls in the low queue window.
   function automatic logic in_window(input logic [7:0] addr);
      in_window = (addr <= ADDR_WIN_LAST);
   endfunction

   logic awready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] status_q, mask_q, rx_frame_cnt_q, rx_count_q;
   logic [2:0] config_q;
   logic [4:0] rx_wr_ptr_q, rx_rd_ptr_q;
   logic [5:0] rx_level_q, rx_blk_cnt_q;
   logic irq_q, rx_in_frame_q, rx_drop_q, rx_hold_q;
   logic [4:0] tx_wr_ptr_q, tx_rd_ptr_q;
   logic [5:0] tx_fill_q;
   logic tx_go_q, tx_last_q, tx_valid_q, tx_end_q, tx_abort_q;
   logic [7:0] tx_data_q, rx_rd_byte, tx_rd_byte;

   // Bus handshakes; one write and one read are in flight at most.
   wire wr_take = S_AXI_AWVALID && S_AXI_WVALID && !awready_q && !bvalid_q;
   wire rd_take = S_AXI_ARVALID && !arready_q && !rvalid_q;
   wire lane0 = S_AXI_WSTRB[0];
   wire [7:0] wbyte = S_AXI_WDATA[7:0];

   // Write decode.
   wire w_win = in_window(S_AXI_AWADDR);
   wire w_status = (S_AXI_AWADDR == ADDR_STATUS);
   wire w_mask = (S_AXI_AWADDR == ADDR_MASK);
   wire w_config = (S_AXI_AWADDR == ADDR_CONFIG);
   wire w_cmd = (S_AXI_AWADDR == ADDR_COMMAND);
   wire w_mapped = w_win || w_status || w_mask || w_config || w_cmd;
   wire tx_push = wr_take && w_win && lane0;
   wire [7:0] clr_bits = (wr_take && w_status && lane0) ? wbyte : 8'h00;
   wire cmd_hit = wr_take && w_cmd && lane0;
   wire cmd_release = cmd_hit && wbyte[CMD_RELEASE];
   wire cmd_rx_reset = cmd_hit && wbyte[CMD_RX_RESET];
   wire cmd_tx_frame = cmd_hit && wbyte[CMD_TX_FRAME];
   wire cmd_tx_end = cmd_hit && wbyte[CMD_TX_END];
   wire cmd_tx_reset = cmd_hit && wbyte[CMD_TX_RESET];

   // Read decode; a window read pops one receive byte.
   wire r_win = in_window(S_AXI_ARADDR);
   wire rx_pop = rd_take && r_win; // [RL1]
   wire [7:0] status_view = status_q & ~mask_q;
   wire [7:0] qstate = {2'b00, tx_go_q, rx_in_frame_q, rx_hold_q,
                        (tx_fill_q == 6'd0), 2'b00};
   logic [31:0] rd_word;
   logic rd_ok;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (r_win) begin
         rd_word = {24'h00_0000, rx_rd_byte}; // [RL1]
      end else if (S_AXI_ARADDR == ADDR_STATUS) begin
         rd_word = {24'h00_0000, status_view & STATUS_LIVE}; // [RL8]
      end else if (S_AXI_ARADDR == ADDR_MASK) begin
         rd_word = {24'h00_0000, mask_q};
      end else if (S_AXI_ARADDR == ADDR_CONFIG) begin
         rd_word = {29'h000_0000, config_q};
      end else if (S_AXI_ARADDR == ADDR_RX_COUNT) begin
         rd_word = {24'h00_0000, rx_count_q}; // [RL5]
      end else if (S_AXI_ARADDR == ADDR_QSTATE) begin
         rd_word = {24'h00_0000, qstate};
      end else if (S_AXI_ARADDR != ADDR_COMMAND) begin
         rd_ok = 1'b0;
      end
   end

   // Receive side conditions.
   wire [5:0] rx_bs = rx_block_bytes(config_q[1:0]); // [RL4]
   wire rx_occupied = rx_hold_q || (rx_level_q != 6'd0);
   wire rx_begin = RX_START && !rx_in_frame_q;
   wire rx_refuse = rx_begin && rx_occupied; // [RL10]
   wire rx_live = rx_in_frame_q && !rx_drop_q;
   wire rx_byte_lost = rx_live && RX_VALID &&
                       (rx_hold_q || rx_level_q == QUEUE_FULL);
   wire rx_store = rx_live && RX_VALID && !rx_byte_lost; // [RL2]
   wire rx_block_done = rx_store && (rx_blk_cnt_q + 6'd1 == rx_bs);
   wire ev_rx_full = rx_block_done && !RX_END; // [RL3]
   wire ev_rx_end = rx_live && RX_END && !rx_byte_lost; // [RL9]
   wire ev_rx_ovf = rx_refuse || rx_byte_lost; // [RL10]

   // Transmit side conditions.
   wire tx_serve = tx_go_q && TX_READY && !TX_COLLISION;
   wire tx_send = tx_serve && (tx_fill_q != 6'd0);
   wire tx_drained = tx_send && (tx_fill_q == 6'd1);
   wire tx_under = tx_serve && (tx_fill_q == 6'd0) && !tx_last_q; // [RL12]
   wire ev_tx_ready = tx_drained; // [RL11]
   wire ev_tx_under = tx_under; // [RL12]
   wire ev_tx_repeat = tx_go_q && TX_COLLISION;
   wire [5:0] tx_bs = config_q[CFG_TX_BS] ? TX_BS_LARGE : TX_BS_SMALL;
   wire tx_room = (tx_fill_q < tx_bs); // [RL7]
   wire tx_accept = tx_push && tx_room && (tx_fill_q != QUEUE_FULL);

   // Collected event pulses in status layout.
   wire [7:0] ev_bits = {ev_rx_end, ev_rx_full, ev_rx_ovf, ev_tx_ready,
                         ev_tx_repeat, ev_tx_under, 2'b00};

   hqa_queue_mem u_rx_mem (
      .clk(REF_CLK),
      .wr_en(rx_store),
      .wr_addr(rx_wr_ptr_q),
      .wr_data(RX_DATA),
      .rd_addr(rx_rd_ptr_q),
      .rd_data(rx_rd_byte)
   );

   hqa_queue_mem u_tx_mem (
      .clk(REF_CLK),
      .wr_en(tx_accept),
      .wr_addr(tx_wr_ptr_q),
      .wr_data(wbyte),
      .rd_addr(tx_rd_ptr_q),
      .rd_data(tx_rd_byte)
   );

   // Write channel: address and data taken together, response next cycle.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         awready_q <= wr_take;
         if (wr_take) begin
            bvalid_q <= 1'b1;
            bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel: data is captured at the address handshake.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         arready_q <= rd_take;
         if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_word;
         end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Status is sticky; a new event beats a clear in the same cycle.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         status_q <= STATUS_RESET; // [RL8]
         mask_q <= MASK_RESET;
         config_q <= CONFIG_RESET;
         irq_q <= 1'b0;
      end else begin
         status_q <= ((status_q & ~clr_bits) | ev_bits) & STATUS_LIVE;
         if (wr_take && w_mask && lane0) begin
            mask_q <= wbyte & STATUS_LIVE;
         end
         if (wr_take && w_config && lane0) begin
            config_q <= wbyte[2:0];
         end
         irq_q <= |(status_q & ~mask_q);
      end
   end

   // Receive queue: one block is held until the host releases it.
   always_ff @(posedge REF_CLK) begin
      if (RST || cmd_rx_reset) begin
         rx_wr_ptr_q <= 5'd0;
         rx_rd_ptr_q <= 5'd0;
         rx_level_q <= 6'd0;
         rx_blk_cnt_q <= 6'd0;
         rx_frame_cnt_q <= 8'h00;
         rx_count_q <= 8'h00;
         rx_in_frame_q <= 1'b0;
         rx_drop_q <= 1'b0;
         rx_hold_q <= 1'b0;
      end else begin
         if (rx_begin) begin
            rx_in_frame_q <= 1'b1;
            rx_drop_q <= rx_refuse; // [RL10]
            rx_blk_cnt_q <= 6'd0;
            rx_frame_cnt_q <= 8'h00;
         end else if (rx_in_frame_q && RX_END) begin
            rx_in_frame_q <= 1'b0;
            rx_drop_q <= 1'b0;
         end else if (rx_byte_lost) begin
            rx_drop_q <= 1'b1; // [RL10]
         end
         if (rx_store) begin
            rx_wr_ptr_q <= rx_wr_ptr_q + 5'd1;
            rx_frame_cnt_q <= rx_frame_cnt_q + 8'd1;
            rx_blk_cnt_q <= rx_block_done ? 6'd0 : rx_blk_cnt_q + 6'd1;
         end
         if (ev_rx_end) begin
            rx_count_q <= rx_frame_cnt_q + {7'd0, rx_store}; // [RL5]
         end
         if (cmd_release) begin
            rx_hold_q <= 1'b0;
            rx_rd_ptr_q <= rx_wr_ptr_q;
            rx_level_q <= 6'd0;
         end else begin
            if (ev_rx_full || ev_rx_end) begin
               rx_hold_q <= 1'b1; // [RL3]
            end
            if (rx_store) begin
               rx_level_q <= rx_level_q + 6'd1; // [RL2]
            end
            if (rx_pop) begin
               rx_rd_ptr_q <= rx_rd_ptr_q + 5'd1; // [RL1]
            end
         end
      end
   end

   // Transmit queue; an abandoned frame is flushed so a retry starts clean.
   always_ff @(posedge REF_CLK) begin
      if (RST || cmd_tx_reset || ev_tx_repeat || tx_under) begin
         tx_wr_ptr_q <= 5'd0;
         tx_rd_ptr_q <= 5'd0;
         tx_fill_q <= 6'd0;
         tx_go_q <= 1'b0;
         tx_last_q <= 1'b0;
      end else begin
         if (tx_accept) begin
            tx_wr_ptr_q <= tx_wr_ptr_q + 5'd1; // [RL6]
         end
         if (tx_send) begin
            tx_rd_ptr_q <= tx_rd_ptr_q + 5'd1;
         end
         if (tx_accept && !tx_send) begin
            tx_fill_q <= tx_fill_q + 6'd1;
         end else if (tx_send && !tx_accept) begin
            tx_fill_q <= tx_fill_q - 6'd1;
         end
         if (cmd_tx_frame) begin
            tx_go_q <= 1'b1;
            tx_last_q <= cmd_tx_end;
         end else if (tx_drained && tx_last_q) begin
            tx_go_q <= 1'b0;
            tx_last_q <= 1'b0;
         end
      end
   end

   // Serializer side outputs are registered; valid marks each byte sent, end and abort are single-cycle pulses.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_valid_q <= 1'b0;
         tx_data_q <= 8'h00;
         tx_end_q <= 1'b0;
         tx_abort_q <= 1'b0;
      end else begin
         tx_valid_q <= tx_send && !cmd_tx_reset;
         tx_end_q <= tx_drained && tx_last_q && !cmd_tx_reset;
         tx_abort_q <= (tx_under || ev_tx_repeat) && !cmd_tx_reset; // [RL12]
         if (tx_send) begin
            tx_data_q <= tx_rd_byte;
         end
      end
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = awready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RRESP = rresp_q;
   assign S_AXI_RDATA = rdata_q;
   assign TX_VALID = tx_valid_q;
   assign TX_DATA = tx_data_q;
   assign TX_END = tx_end_q;
   assign TX_ABORT = tx_abort_q;
   assign IRQ = irq_q;

endmodule // hqa_top

//--- testbench/hqa_top_properties.sv
`timescale 1ns/1ps
// Watches the bus and link ports of the queue access block.
module hqa_top_properties
   import hqa_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TX_VALID,
   input wire logic TX_END,
   input wire logic TX_ABORT,
   input wire logic IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // Requests that the slave must take at this edge.
   sequence s_wr_req;
      S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
   endsequence
   sequence s_rd_req;
      S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
   endsequence
   property p_wr_ans;
      s_wr_req |=> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID;
   endproperty
   property p_rd_ans;
      s_rd_req |=> S_AXI_ARREADY && S_AXI_RVALID && !(|S_AXI_RDATA[31:8]);
   endproperty
   property p_win_ok;
      s_rd_req ##0 S_AXI_ARADDR <= ADDR_WIN_LAST |=> S_AXI_RRESP == RESP_OKAY;
   endproperty
   property p_stat_low;
      s_rd_req ##0 S_AXI_ARADDR == ADDR_STATUS |=> S_AXI_RDATA[1:0] == 2'h0;
   endproperty
   property p_r_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   property p_b_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
   endproperty
   property p_end_data;
      TX_END |-> TX_VALID && !TX_ABORT;
   endproperty
   property p_abort;
      TX_ABORT |-> !TX_VALID ##1 !TX_ABORT;
   endproperty
   // Reset must quiet the outputs even though the default disable is on.
   property p_rst;
      disable iff (1'b0) RST |=> !IRQ && !S_AXI_RVALID && !TX_VALID;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write request not answered");
   a_rd_ans: assert property (p_rd_ans)
      else $error("read request not answered");
   a_win_ok: assert property (p_win_ok)
      else $error("window read refused");
   a_stat_low: assert property (p_stat_low)
      else $error("status low bits set");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   a_end_data: assert property (p_end_data)
      else $error("frame end without byte");
   a_abort: assert property (p_abort)
      else $error("abort pulse malformed");
   a_rst: assert property (p_rst)
      else $error("outputs active after reset");
endmodule // hqa_top_properties

bind hqa_top hqa_top_properties u_props (.REF_CLK, .RST, .S_AXI_ARADDR,
   .S_AXI_AWVALID, .S_AXI_WVALID, .S_AXI_AWREADY, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TX_VALID,
   .TX_END, .TX_ABORT, .IRQ);

//--- testbench/hqa_link_model.sv
`timescale 1ns/1ps
// Link stand-in: asks for a transmit byte every GAP+1 cycles while run.
module hqa_link_model #(
   parameter int GAP = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_end,
   input wire logic tx_abort,
   output logic tx_ready
);
   int cnt_q = 0;
   int ends = 0;
   int aborts = 0;
   logic [7:0] got [$];
   initial tx_ready = 1'b0;
   // The gap paces requests like a serializer shifting bits out, so the
   // queue drains slowly enough for the host to be late.
   always @(posedge clk) begin
      tx_ready <= run && !rst && cnt_q == GAP;
      cnt_q <= (rst || !run || cnt_q == GAP) ? 0 : cnt_q + 1;
      if (tx_valid) got.push_back(tx_data);
      if (tx_end) ends <= ends + 1;
      if (tx_abort) aborts <= aborts + 1;
   end
endmodule // hqa_link_model

//--- testbench/hqa_top_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the queue access block.
module hqa_top_bench import hqa_pkg::*;;
   logic REF_CLK = 1'b0, RST = 1'b1, run = 1'b0;
   logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, RX_DATA = '0, TX_DATA;
   logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rdv;
   logic [3:0] S_AXI_WSTRB = 4'hF;
   logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
   logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, RX_START = '0;
   logic RX_VALID = '0, RX_END = '0, TX_COLLISION = '0, TX_READY;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, TX_VALID, TX_END, TX_ABORT, IRQ;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
   int errors = 0, total_checks = 0, cycles = 0, bs;
   // Rows: address, expected byte, expected response.
   localparam logic [7:0] ROW_A [6] = '{ADDR_STATUS, ADDR_MASK, ADDR_CONFIG,
      ADDR_RX_COUNT, 8'h3C, ADDR_QSTATE};
   localparam logic [7:0] ROW_E [6] = '{STATUS_RESET & ~MASK_RESET,
      MASK_RESET, {5'h00, CONFIG_RESET}, 8'h00, 8'h00, 8'h04};
   localparam logic [1:0] ROW_R [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY,
      RESP_OKAY, RESP_SLVERR, RESP_OKAY};
   hqa_top u_dut (.REF_CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .RX_START, .RX_VALID,
      .RX_DATA, .RX_END, .TX_READY, .TX_COLLISION, .TX_VALID, .TX_DATA,
      .TX_END, .TX_ABORT, .IRQ);
   hqa_link_model u_link (.clk(REF_CLK), .rst(RST), .run,
      .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_end(TX_END),
      .tx_abort(TX_ABORT), .tx_ready(TX_READY));
   always #12.5 REF_CLK = ~REF_CLK;
   // A hung handshake ends the run here.
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge REF_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h00_0000, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do @(posedge REF_CLK); while (S_AXI_AWREADY !== 1'b1);
      S_AXI_AWVALID <= 1'b0;
      S_AXI_WVALID <= 1'b0;
      while (S_AXI_BVALID !== 1'b1) @(posedge REF_CLK);
      rsp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge REF_CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      while (S_AXI_RVALID !== 1'b1) @(posedge REF_CLK);
      rdv = S_AXI_RDATA;
      rsp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(rdv[7:0], e);
   endtask
   task automatic ww(input logic [7:0] a, input logic [7:0] d);
      wr(a, d);
      chk({6'h00, rsp}, {6'h00, RESP_OKAY});
   endtask
   // One receive link cycle; the data line toggles once the byte is gone.
   task automatic rxp(input logic s, v, e, input logic [7:0] b);
      @(posedge REF_CLK);
      {RX_START, RX_VALID, RX_END, RX_DATA} <= {s, v, e, b};
      @(posedge REF_CLK);
      {RX_START, RX_VALID, RX_END, RX_DATA} <= {3'h0, ~b};
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge REF_CLK);
      RST <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ROW_A[i]);
         chk({6'h00, rsp}, {6'h00, ROW_R[i]});
         if (ROW_R[i] === RESP_OKAY) chk(rdv[7:0], ROW_E[i]);
      end
      $display("test register table done");
      // Pool ready is pending but masked at reset, so the line stays low.
      chk({7'h00, IRQ}, 8'h00);
      ww(ADDR_MASK, 8'h00);
      repeat (2) @(posedge REF_CLK);
      chk({7'h00, IRQ}, 8'h01);
      rr(ADDR_STATUS, STATUS_RESET);
      ww(ADDR_STATUS, 8'h10);
      repeat (2) @(posedge REF_CLK);
      chk({7'h00, IRQ}, 8'h00);
      wr(8'h3C, 8'h55);
      chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
      $display("test interrupt done");
      // Every receive block size: no pool full one byte short of a block.
      for (int k = 0; k < 4; k++) begin
         bs = 4 << k;
         ww(ADDR_CONFIG, 8'(k));
         ww(ADDR_STATUS, 8'hFC);
         rxp(1'b1, 1'b0, 1'b0, 8'h00);
         for (int i = 0; i < bs; i++) begin
            if (i == bs - 1) rr(ADDR_STATUS, 8'h00);
            rxp(1'b0, 1'b1, 1'b0, 8'(i + 16 * k));
         end
         rr(ADDR_STATUS, 8'h40);
         for (int i = 0; i < bs; i++)
            rr(8'((i * 7) % 32), 8'(i + 16 * k));
         ww(ADDR_COMMAND, 8'h80);
         rxp(1'b0, 1'b0, 1'b1, 8'h00);
         rr(ADDR_STATUS, 8'hC0);
         rr(ADDR_RX_COUNT, 8'(bs));
         // Message end holds the queue too, so it must be released.
         ww(ADDR_COMMAND, 8'h80);
      end
      $display("test receive sizes done");
      ww(ADDR_CONFIG, 8'h00);
      ww(ADDR_STATUS, 8'hFC);
      rxp(1'b1, 1'b0, 1'b0, 8'h00);
      rxp(1'b0, 1'b1, 1'b0, 8'h5A);
      rxp(1'b0, 1'b0, 1'b1, 8'h00);
      rxp(1'b1, 1'b0, 1'b0, 8'h00);
      rxp(1'b0, 1'b1, 1'b0, 8'h33);
      rr(ADDR_STATUS, 8'hA0);
      rr(8'h11, 8'h5A);
      ww(ADDR_COMMAND, 8'h40);
      $display("test receive overflow done");
      // Three bytes, well under the 16 byte block, as a whole frame.
      ww(ADDR_STATUS, 8'hFC);
      for (int i = 0; i < 3; i++) ww(8'(i * 13), 8'(8'hC0 + i));
      ww(ADDR_COMMAND, 8'h0A);
      run <= 1'b1;
      wait (u_link.ends == 1);
      @(posedge REF_CLK);
      run <= 1'b0;
      chk(8'(u_link.got.size()), 8'h03);
      for (int i = 0; i < 3; i++) chk(u_link.got[i], 8'(8'hC0 + i));
      rr(ADDR_STATUS, 8'h10);
      $display("test transmit frame done");
      // The host never refills, so the link drains the queue mid-frame.
      ww(ADDR_STATUS, 8'hFC);
      ww(8'h00, 8'h77);
      ww(8'h1F, 8'h78);
      ww(ADDR_COMMAND, 8'h08);
      run <= 1'b1;
      wait (u_link.aborts == 1);
      @(posedge REF_CLK);
      run <= 1'b0;
      chk(8'(u_link.got.size()), 8'h05);
      rr(ADDR_STATUS, 8'h14);
      ww(ADDR_STATUS, 8'hFC);
      ww(8'h00, 8'h99);
      ww(ADDR_COMMAND, 8'h08);
      @(posedge REF_CLK);
      TX_COLLISION <= 1'b1;
      @(posedge REF_CLK);
      TX_COLLISION <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      chk(8'(u_link.aborts), 8'h02);
      rd(ADDR_STATUS);
      chk(rdv[7:0] & 8'h08, 8'h08);
      $display("test underrun and collision done");
      // A stored byte clears the empty flag; transmit reset sets it again.
      ww(8'h00, 8'hAA);
      rr(ADDR_QSTATE, 8'h00);
      ww(ADDR_COMMAND, 8'h01);
      rr(ADDR_QSTATE, 8'h04);
      $display("test transmit reset done");
      conclude();
   end
endmodule // hqa_top_bench
